// ==== hw/tbac_params.svh ====
// constants for the twelve-bit converter control block
`ifndef TBAC_PARAMS_SVH
`define TBAC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define TBAC_IDX_CTRL     8'hb1
`define TBAC_IDX_RES_HI   8'hb2
`define TBAC_IDX_CKS_RES  8'hb3

// ----------------------------------------------------------------------------
// conversion_control field positions
// ----------------------------------------------------------------------------
`define TBAC_CTRL_EN_BIT    7
`define TBAC_CTRL_START_BIT 6
`define TBAC_CTRL_DONE_BIT  5
`define TBAC_CTRL_PATH_BIT  4
`define TBAC_CTRL_SEL_MSB   2
`define TBAC_CTRL_SEL_LSB   0

// ----------------------------------------------------------------------------
// clock_select_and_result_nibble field positions
// ----------------------------------------------------------------------------
`define TBAC_CKS_HI_BIT   6
`define TBAC_CKS_RES_BIT  5
`define TBAC_CKS_LO_BIT   4
`define TBAC_CKS_NIB_MSB  3

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define TBAC_SEL_FIRST    3'h0
`define TBAC_SEL_SECOND   3'h1
`define TBAC_RES_RST      1'b0
`define TBAC_CONV_LAST    6'h3f
`define TBAC_STEP_PHASE   2'h3
`define TBAC_TRIAL_INIT   12'h800
`define TBAC_NIB_ZERO     4'h0

`endif

// ==== hw/tbac_pkg.sv ====
// types shared by the twelve-bit converter control block
package tbac_pkg;

  // sequencer states
  typedef enum logic [0:0] {
    TBAC_IDLE = 1'b0,
    TBAC_RUN  = 1'b1
  } tbac_state_t;

  // conversion clock source codes
  typedef enum logic [1:0] {
    TBAC_CK_CPU4  = 2'b00,
    TBAC_CK_CPU2  = 2'b01,
    TBAC_CK_HOSC  = 2'b10,
    TBAC_CK_HOSC2 = 2'b11
  } tbac_cks_t;

  // conversion_control contents
  typedef struct packed {
    logic       en;
    logic       start;
    logic       done;
    logic       path;
    logic [2:0] sel;
  } tbac_ctrl_t;

  // writable part of clock_select_and_result_nibble
  typedef struct packed {
    tbac_cks_t cks;
    logic      res12;
  } tbac_cksel_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tbac_apb_req_t;

endpackage

// ==== hw/tbac_tick_gen.sv ====
// conversion clock enable generator
`timescale 1ns/1ps
`include "tbac_params.svh"

module tbac_tick_gen
  import tbac_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      run,
  input  tbac_cks_t      clk_src,
  input  wire logic      slow_mode,
  input  wire logic      hosc_tick,
  output logic           conv_tick
);

  logic [1:0] div_q;
  logic       hosc_half_q;

  // ----------------------------------------------------------------------------
  // cpu clock prescaler, restarted when a conversion starts from idle so the first period is whole; a relaunch mid-run keeps counting
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // high oscillator halver
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      hosc_half_q <= 1'b0;
    end else if (hosc_tick) begin
      hosc_half_q <= ~hosc_half_q;
    end
  end

  // ----------------------------------------------------------------------------
  // tick select; high oscillator sources give no ticks in slow mode
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      conv_tick <= 1'b0;
    end else begin
      unique case (clk_src)
        TBAC_CK_CPU4:  conv_tick <= (div_q == 2'h3);
        TBAC_CK_CPU2:  conv_tick <= div_q[0];
        TBAC_CK_HOSC:  conv_tick <= hosc_tick && !slow_mode;
        TBAC_CK_HOSC2: conv_tick <= hosc_tick && hosc_half_q && !slow_mode;
      endcase
    end
  end

endmodule

// ==== hw/tbac_top.sv ====
// register file and sequencer of the two-input twelve-bit converter
// Contract
// - converter stays off while enable bit is 0, works once set to 1.
// - done flag reads 0 while converting; completion sets it, clears start.
// - result registers load in the same cycle the done flag rises.
// - path enable 0 disconnects the input, 1 connects the chosen channel.
// - select code 000 routes first input, 001 second, others reserved.
// - clock source 00 cpu/4, 01 cpu/2, 10 high osc, 11 high osc/2.
// - high oscillator sources only in normal mode; cpu sources in both.
// - upper result register holds result bits 11 down to 4.
// - result bits 3 down to 0 sit read-only in clock-select low nibble.
// - resolution bit chooses 8 or 12 bits, 1 meaning 12 bits.
// - 8-bit mode gives only bits 11..4 meaningful; 12-bit gives all.
// - result registers ignore software writes.
// - result registers have no defined value after reset.
// - a conversion lasts exactly 64 conversion clock periods.
// - result is unsigned straight binary, 4096 steps of the high reference.
`timescale 1ns/1ps
`include "tbac_params.svh"

module tbac_top
  import tbac_pkg::*;
#(
  parameter int RES_W = 12
)
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  tbac_apb_req_t         apb_req,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [RES_W-1:0] analog_input_first,
  input  wire logic [RES_W-1:0] analog_input_second,
  input  wire logic             hosc_tick,
  input  wire logic             slow_mode,
  output logic                  conv_power_enable,
  output logic                  input_path_enable,
  output logic [2:0]            input_select_field,
  output logic                  conv_active
);

  // ----------------------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------------------
  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic logic is_reg(input logic [11:0] addr, input logic [7:0] idx);
    is_reg = (addr == byte_addr(idx));
  endfunction

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  tbac_ctrl_t        ctrl_q;
  tbac_cksel_t       cksel_q;
  logic [RES_W-1:0]  result_q;
  tbac_state_t       state_q;
  logic [5:0]        tick_cnt_q;
  logic [RES_W-1:0]  sample_q;
  logic [RES_W-1:0]  acc_q;
  logic [RES_W-1:0]  trial_q;
  logic [31:0]       rdata_q;

  logic              setup_ph;
  logic              access_ph;
  logic              hit_ctrl;
  logic              hit_hi;
  logic              hit_cks;
  logic              mapped;
  logic              wr_ctrl;
  logic              wr_cks;
  logic              launch;
  logic              conv_tick;
  logic              finish;
  logic              step_ok;
  logic [RES_W-1:0]  chan_value;
  logic [RES_W-1:0]  probe;
  tbac_ctrl_t        wctrl;

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  assign setup_ph  = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign hit_ctrl  = is_reg(apb_req.paddr, `TBAC_IDX_CTRL);
  assign hit_hi    = is_reg(apb_req.paddr, `TBAC_IDX_RES_HI);
  assign hit_cks   = is_reg(apb_req.paddr, `TBAC_IDX_CKS_RES);
  assign mapped    = hit_ctrl || hit_hi || hit_cks;
  assign wr_ctrl   = access_ph && apb_req.pwrite && hit_ctrl;
  assign wr_cks    = access_ph && apb_req.pwrite && hit_cks;

  // zero wait states; unmapped addresses answer with an error
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !mapped;
  assign prdata    = rdata_q;

  // write data viewed as a control word
  assign wctrl.en    = apb_req.pwdata[`TBAC_CTRL_EN_BIT];
  assign wctrl.start = apb_req.pwdata[`TBAC_CTRL_START_BIT];
  assign wctrl.done  = apb_req.pwdata[`TBAC_CTRL_DONE_BIT];
  assign wctrl.path  = apb_req.pwdata[`TBAC_CTRL_PATH_BIT];
  assign wctrl.sel   = apb_req.pwdata[`TBAC_CTRL_SEL_MSB:`TBAC_CTRL_SEL_LSB];

  // a start write only launches when the converter is enabled by the same word
  assign launch = wr_ctrl && wctrl.start && wctrl.en;

  // ----------------------------------------------------------------------------
  // read data, captured in the setup phase so prdata is a flop output
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      rdata_q <= 32'h0000_0000;
      if (hit_ctrl) begin
        rdata_q[`TBAC_CTRL_EN_BIT]    <= ctrl_q.en;
        rdata_q[`TBAC_CTRL_START_BIT] <= ctrl_q.start;
        rdata_q[`TBAC_CTRL_DONE_BIT]  <= ctrl_q.done;
        rdata_q[`TBAC_CTRL_PATH_BIT]  <= ctrl_q.path;
        rdata_q[`TBAC_CTRL_SEL_MSB:`TBAC_CTRL_SEL_LSB] <= ctrl_q.sel;
      end else if (hit_hi) begin
        rdata_q[7:0] <= result_q[RES_W-1:RES_W-8];
      end else if (hit_cks) begin
        rdata_q[`TBAC_CKS_HI_BIT]  <= cksel_q.cks[1];
        rdata_q[`TBAC_CKS_RES_BIT] <= cksel_q.res12;
        rdata_q[`TBAC_CKS_LO_BIT]  <= cksel_q.cks[0];
        rdata_q[`TBAC_CKS_NIB_MSB:0] <= result_q[3:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // conversion_control: hardware completion wins over a software clear
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.en    <= wctrl.en;
        ctrl_q.path  <= wctrl.path;
        ctrl_q.sel   <= wctrl.sel;
        ctrl_q.start <= wctrl.start && wctrl.en;
        ctrl_q.done  <= wctrl.start ? 1'b0 : wctrl.done;
      end else if (!ctrl_q.en) begin
        ctrl_q.start <= 1'b0;
      end
      if (finish && !launch) begin
        ctrl_q.done  <= 1'b1;
        ctrl_q.start <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // clock source and resolution; the result nibble bits are not writable
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cksel_q.cks   <= TBAC_CK_CPU4;
      cksel_q.res12 <= `TBAC_RES_RST;
    end else if (wr_cks) begin
      cksel_q.cks   <= tbac_cks_t'({apb_req.pwdata[`TBAC_CKS_HI_BIT],
                                    apb_req.pwdata[`TBAC_CKS_LO_BIT]});
      cksel_q.res12 <= apb_req.pwdata[`TBAC_CKS_RES_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // input routing; reserved codes and a closed path give zero
  // ----------------------------------------------------------------------------
  always_comb begin
    chan_value = '0;
    if (ctrl_q.path) begin
      if (ctrl_q.sel == `TBAC_SEL_FIRST) begin
        chan_value = analog_input_first;
      end else if (ctrl_q.sel == `TBAC_SEL_SECOND) begin
        chan_value = analog_input_second;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // conversion clock
  // ----------------------------------------------------------------------------
  tbac_tick_gen u_tick (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .run       (state_q == TBAC_RUN),
    .clk_src   (cksel_q.cks),
    .slow_mode (slow_mode),
    .hosc_tick (hosc_tick),
    .conv_tick (conv_tick)
  );

  // the 64th tick ends the conversion
  assign finish  = (state_q == TBAC_RUN) && conv_tick && (tick_cnt_q == `TBAC_CONV_LAST);
  // 8-bit mode stops trying bits once bit 4 is decided
  assign step_ok = cksel_q.res12 || (trial_q[RES_W-1:4] != '0);
  assign probe   = acc_q | trial_q;

  // ----------------------------------------------------------------------------
  // sequencer state and period count
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= TBAC_IDLE;
      tick_cnt_q <= 6'h00;
    end else if (launch) begin
      state_q    <= TBAC_RUN;
      tick_cnt_q <= 6'h00;
    end else begin
      unique case (state_q)
        TBAC_IDLE: begin
          tick_cnt_q <= 6'h00;
        end
        TBAC_RUN: begin
          // clearing enable or start aborts the conversion
          if (!ctrl_q.en || !ctrl_q.start || finish) begin
            state_q <= TBAC_IDLE;
          end else if (conv_tick) begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // successive approximation, one bit every fourth tick, msb first
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_q <= '0;
      acc_q    <= '0;
      trial_q  <= '0;
    end else if (launch) begin
      sample_q <= chan_value; // held for the whole conversion
      acc_q    <= '0;
      trial_q  <= `TBAC_TRIAL_INIT;
    end else if (state_q == TBAC_RUN && conv_tick &&
                 tick_cnt_q[1:0] == `TBAC_STEP_PHASE && trial_q != '0 && step_ok) begin
      if (sample_q >= probe) begin
        acc_q <= probe;
      end
      trial_q <= trial_q >> 1;
    end
  end

  // ----------------------------------------------------------------------------
  // result: no reset on purpose, loaded only at completion
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (finish && !launch) begin
      result_q <= cksel_q.res12 ? acc_q : {acc_q[RES_W-1:4], `TBAC_NIB_ZERO};
    end
  end

  // ----------------------------------------------------------------------------
  // outputs toward the analog macro
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_power_enable  <= 1'b0;
      input_path_enable  <= 1'b0;
      input_select_field <= 3'h0;
      conv_active        <= 1'b0;
    end else begin
      conv_power_enable  <= ctrl_q.en;
      input_path_enable  <= ctrl_q.path;
      input_select_field <= ctrl_q.sel;
      conv_active        <= (state_q == TBAC_RUN) && !finish;
    end
  end

endmodule

// ==== tb/tbac_top_sva.sv ====
// concurrent checks on the ports of the converter control block
`timescale 1ns/1ps

module tbac_top_sva
  import tbac_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  tbac_apb_req_t    apb_req,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        conv_power_enable,
  input  wire logic        input_path_enable,
  input  wire logic [2:0]  input_select_field,
  input  wire logic        conv_active
);
  // ----------------------------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------------------------
  logic       acc;
  logic       wr_ctrl;
  logic       wr_start;
  logic       mapped;
  logic [9:0] run_q;

  // access phase decode, mirrors the bus map
  assign acc      = apb_req.psel & apb_req.penable;
  assign wr_ctrl  = acc & apb_req.pwrite & (apb_req.paddr == 12'h2c4);
  assign wr_start = wr_ctrl & apb_req.pwdata[7] & apb_req.pwdata[6];
  assign mapped   = apb_req.paddr inside {12'h2c4, 12'h2c8, 12'h2cc};

  // busy length counter, saturates so a hung run cannot wrap
  always_ff @(posedge clk) begin
    if (sys_rst || !conv_active) run_q <= 10'h000;
    else if (run_q != 10'h3ff) run_q <= run_q + 10'h001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  // outputs are a second flop stage behind the control register, so two cycles after the write
  en_copy_a: assert property (wr_ctrl |-> ##2 conv_power_enable == $past(apb_req.pwdata[7], 2))
    else $error("enable output does not follow control write");
  // enable clear reaches the sequencer one cycle late and the busy flop one more
  off_abort_a: assert property (wr_ctrl && !apb_req.pwdata[7] |-> ##3 !conv_active)
    else $error("converter runs while disabled");
  path_copy_a: assert property (wr_ctrl |-> ##2 input_path_enable == $past(apb_req.pwdata[4], 2))
    else $error("path enable output does not follow control write");
  sel_copy_a: assert property (wr_ctrl |-> ##2 input_select_field == $past(apb_req.pwdata[2:0], 2))
    else $error("select output does not follow control write");
  launch_cause_a: assert property ($rose(conv_active) |-> $past(wr_start) || $past(wr_start, 2))
    else $error("conversion began without a start write");
  // a control write just before the read may legally abort, so it is excluded
  busy_flag_a: assert property (acc && !apb_req.pwrite && apb_req.paddr == 12'h2c4 && $past(conv_active)
    && !$past(wr_ctrl, 2) |-> prdata[6:5] == 2'b10)
    else $error("done set or start clear while converting");
  // an abort write drops the busy flag three cycles later, so all three are excluded
  run_length_a: assert property ($fell(conv_active) && !$past(wr_ctrl) && !$past(wr_ctrl, 2)
    && !$past(wr_ctrl, 3) |-> $past(run_q) >= 10'd63)
    else $error("conversion finished too early");
  err_map_a: assert property (acc |-> pready && (pslverr == !mapped))
    else $error("bus error flag wrong for address");
endmodule

bind tbac_top tbac_top_sva u_sva (
  .clk                (clk),
  .sys_rst            (sys_rst),
  .apb_req            (apb_req),
  .prdata             (prdata),
  .pready             (pready),
  .pslverr            (pslverr),
  .conv_power_enable  (conv_power_enable),
  .input_path_enable  (input_path_enable),
  .input_select_field (input_select_field),
  .conv_active        (conv_active)
);

// ==== tb/twelve_bit_adc_control_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps

module twelve_bit_adc_control_tb
  import tbac_pkg::*;
;
  // ----------------------------------------------------------------------------
  // signals and case table
  // ----------------------------------------------------------------------------
  localparam logic [11:0] A_CTRL = 12'h2c4;
  localparam logic [11:0] A_HI   = 12'h2c8;
  localparam logic [11:0] A_CKS  = 12'h2cc;

  typedef struct {
    logic [1:0]  src;
    logic        res;
    logic [2:0]  sel;
    logic        path;
    logic [11:0] a;
    logic [11:0] b;
    logic [7:0]  hi;
    logic [3:0]  nib;
  } tbac_row_t;

  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  tbac_apb_req_t req = '0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [11:0]   ain_a = 12'h000;
  logic [11:0]   ain_b = 12'h000;
  logic          hosc_tick = 1'b0;
  logic          slow_mode = 1'b0;
  logic          conv_power_enable;
  logic          input_path_enable;
  logic          conv_active;
  logic [2:0]    input_select_field;
  logic [1:0]    hcnt = 2'h0;
  logic [31:0]   rd;
  logic          perr;
  logic [7:0]    prev_hi = 8'hxx;
  int            errors = 0;
  int            tests_run = 0;
  int            act_cnt = 0;

  // source, resolution, select, path, inputs, expected upper byte and nibble
  tbac_row_t rows [7] = '{
    '{2'b00, 1'b1, 3'h0, 1'b1, 12'h5a3, 12'h000, 8'h5a, 4'h3},
    '{2'b01, 1'b1, 3'h1, 1'b1, 12'h000, 12'hfff, 8'hff, 4'hf},
    '{2'b10, 1'b1, 3'h0, 1'b1, 12'h001, 12'hfff, 8'h00, 4'h1},
    '{2'b11, 1'b0, 3'h1, 1'b1, 12'h000, 12'h8c7, 8'h8c, 4'h0},
    '{2'b00, 1'b1, 3'h2, 1'b1, 12'hfff, 12'hfff, 8'h00, 4'h0},
    '{2'b01, 1'b1, 3'h0, 1'b0, 12'hfff, 12'hfff, 8'h00, 4'h0},
    '{2'b01, 1'b1, 3'h1, 1'b1, 12'hfff, 12'h000, 8'h00, 4'h0}
  };

  tbac_top DUT (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .apb_req             (req),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .analog_input_first  (ain_a),
    .analog_input_second (ain_b),
    .hosc_tick           (hosc_tick),
    .slow_mode           (slow_mode),
    .conv_power_enable   (conv_power_enable),
    .input_path_enable   (input_path_enable),
    .input_select_field  (input_select_field),
    .conv_active         (conv_active)
  );

  // clock, oscillator stand-in one pulse every third cycle, busy counter
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    hcnt <= (hcnt == 2'h2) ? 2'h0 : hcnt + 2'h1;
    hosc_tick <= (hcnt == 2'h2);
    if (conv_active === 1'b1) act_cnt <= act_cnt + 1;
  end

  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one bus transfer; answer taken at the rising edge with pready high, released right after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk(pready, 1'b1);
    rd = prdata;
    perr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // polls the done flag under a bounded count
  task automatic wait_done();
    int i;
    i = 0;
    do begin
      apb(1'b0, A_CTRL, 8'h00);
      i++;
    end while (rd[5] !== 1'b1 && i < 300);
    chk(rd[7:5], 3'b101);
  endtask

  task automatic convert(input tbac_row_t r);
    int per;
    per = (r.src == 2'b00) ? 4 : (r.src == 2'b01) ? 2 : (r.src == 2'b10) ? 3 : 6;
    ain_a <= r.a;
    ain_b <= r.b;
    apb(1'b1, A_CKS, {1'b0, r.src[1], r.res, r.src[0], 4'h0});
    apb(1'b1, A_CTRL, {3'b100, r.path, 1'b0, r.sel});
    // pin copies sit two flops behind the write
    repeat (2) @(posedge clk);
    chk(input_select_field, r.sel);
    chk(input_path_enable, r.path);
    act_cnt = 0;
    apb(1'b1, A_CTRL, {3'b110, r.path, 1'b0, r.sel});
    apb(1'b0, A_CTRL, 8'h00);
    chk(rd[6:5], 2'b10);
    apb(1'b0, A_HI, 8'h00);
    if (!$isunknown(prev_hi)) chk(rd, prev_hi);
    wait_done();
    chk(act_cnt >= 63 * per && act_cnt <= 65 * per, 1'b1);
    apb(1'b0, A_HI, 8'h00);
    chk(rd, r.hi);
    apb(1'b0, A_CKS, 8'h00);
    chk(rd[3:0], r.nib);
    prev_hi = r.hi;
  endtask

  // ----------------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, A_CTRL, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, A_CKS, 8'h00);
    chk(rd[7:4], 4'h0);
    // start with enable clear is refused
    apb(1'b1, A_CTRL, 8'h50);
    repeat (4) @(posedge clk);
    chk(conv_active, 1'b0);
    chk(conv_power_enable, 1'b0);
    // settle time after enabling
    apb(1'b1, A_CTRL, 8'h80);
    repeat (2) @(posedge clk);
    chk(conv_power_enable, 1'b1);
    repeat (10000) @(posedge clk);
    foreach (rows[k]) convert(rows[k]);
    // result registers are read-only
    apb(1'b1, A_HI, 8'ha5);
    chk(perr, 1'b0);
    apb(1'b0, A_HI, 8'h00);
    chk(rd, prev_hi);
    apb(1'b1, A_CKS, 8'h6f);
    apb(1'b0, A_CKS, 8'h00);
    chk(rd, 32'h60);
    // unmapped place answers with an error and reads zero
    apb(1'b0, 12'h2d0, 8'h00);
    chk({perr, rd}, {1'b1, 32'h0});
    // restart mid-run takes the newly sampled input
    ain_a <= 12'h123;
    apb(1'b1, A_CTRL, 8'hd0);
    repeat (50) @(posedge clk);
    ain_a <= 12'h9be;
    apb(1'b1, A_CTRL, 8'hd0);
    apb(1'b0, A_CTRL, 8'h00);
    chk(rd[6:5], 2'b10);
    wait_done();
    apb(1'b0, A_HI, 8'h00);
    chk(rd, 32'h9b);
    apb(1'b0, A_CKS, 8'h00);
    chk(rd[3:0], 4'he);
    // slow mode set with the high osc source from the read-only check still selected; abort keeps the old result
    slow_mode <= 1'b1;
    apb(1'b1, A_CTRL, 8'hd0);
    repeat (300) @(posedge clk);
    chk(conv_active, 1'b1);
    apb(1'b1, A_CTRL, 8'h90);
    repeat (3) @(posedge clk);
    chk(conv_active, 1'b0);
    apb(1'b0, A_HI, 8'h00);
    chk(rd, 32'h9b);
    prev_hi = 8'h9b;
    convert(rows[0]);
    // converter switched off before sleep
    apb(1'b1, A_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    chk(conv_power_enable, 1'b0);
    close_out();
  end

  // watchdog, far beyond the expected run of about twelve and a half thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
